// >>> inc/tmr_pkg.sv
// Constants, encodings and carrier types for the 16-bit timer block.
// Assumes an 8-bit register port with one-cycle strobes on a single clock.
package tmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL_A  = 8'h00;
  localparam logic [7:0] ADR_CTRL_B  = 8'h01;
  localparam logic [7:0] ADR_CNT_LO  = 8'h02;
  localparam logic [7:0] ADR_CNT_HI  = 8'h03;
  localparam logic [7:0] ADR_CAP_LO  = 8'h04;
  localparam logic [7:0] ADR_CAP_HI  = 8'h05;
  localparam logic [7:0] ADR_CMPA_LO = 8'h06;
  localparam logic [7:0] ADR_CMPA_HI = 8'h07;
  localparam logic [7:0] ADR_CMPB_LO = 8'h08;
  localparam logic [7:0] ADR_CMPB_HI = 8'h09;
  localparam logic [7:0] ADR_FLAG    = 8'h0a;
  localparam logic [7:0] ADR_MASK    = 8'h0b;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CA_MODE_LO  = 0;
  localparam int CA_TRIG_SRC = 2;
  localparam int CA_WAVE_B   = 5;
  localparam int CA_WAVE_A   = 7;
  localparam int CB_CLK_LO   = 0;
  localparam int CB_MODE_HI  = 3;
  localparam int CB_EDGE     = 6;
  localparam int CB_FILT     = 7;
  localparam int FL_OVF      = 0;
  localparam int FL_MA       = 1;
  localparam int FL_MB       = 2;
  localparam int FL_CAP      = 5;
  localparam logic [7:0] FLAG_USED = 8'h27;

  ////////////////////////////////////////////////////////////////////////////
  // Counter landmarks
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL    = 16'hffff;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and filter
  localparam int PRE_W     = 10;
  localparam int TAP8_W    = 3;
  localparam int TAP64_W   = 6;
  localparam int TAP256_W  = 8;
  localparam int TAP1024_W = 10;
  localparam int FLT_LEN   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  typedef enum logic [3:0] {
    MD_NORMAL  = 4'h0,
    MD_PWM8    = 4'h1,
    MD_PWM9    = 4'h2,
    MD_PWM10   = 4'h3,
    MD_CTC_A   = 4'h4,
    MD_CTC_CAP = 4'hc,
    MD_PWM_CAP = 4'he,
    MD_PWM_A   = 4'hf
  } tmr_mode_t;

  typedef enum logic [2:0] {
    CS_OFF      = 3'h0,
    CS_DIV1     = 3'h1,
    CS_DIV8     = 3'h2,
    CS_DIV64    = 3'h3,
    CS_DIV256   = 3'h4,
    CS_DIV1024  = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } tmr_clk_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr_bus_req_t;

endpackage

// >>> hw/tmr_tick_sel.sv
// Clock-select logic: free-running prescaler, external pin edge detect.
// Assumes the external count pin is already synchronous to ref_clk.
`timescale 1ns/1ns
module tmr_tick_sel #(
  parameter int PRE_W = tmr_pkg::PRE_W
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] clk_sel,
  input  wire logic       ext_count_pin,
  output logic            timer_tick
);

  ////////////////////////////////////////////////////////////////////////////
  logic [PRE_W-1:0] pre_q;
  logic             ext_s_q;
  logic             ext_p_q;
  wire              tap8    = &pre_q[tmr_pkg::TAP8_W-1:0];
  wire              tap64   = &pre_q[tmr_pkg::TAP64_W-1:0];
  wire              tap256  = &pre_q[tmr_pkg::TAP256_W-1:0];
  wire              tap1024 = &pre_q[tmr_pkg::TAP1024_W-1:0];
  wire              ext_r   = ext_s_q & ~ext_p_q;
  wire              ext_f   = ~ext_s_q & ext_p_q;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_q   <= '0;
      ext_s_q <= 1'b0;
      ext_p_q <= 1'b0;
    end
    else
    begin
      pre_q   <= pre_q + 1'b1;
      ext_s_q <= ext_count_pin;
      ext_p_q <= ext_s_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source and edge choice; no source keeps the counter idle
  always_comb
  begin
    case (tmr_pkg::tmr_clk_t'(clk_sel))
      tmr_pkg::CS_OFF:      timer_tick = 1'b0; // see [R10]
      tmr_pkg::CS_DIV1:     timer_tick = 1'b1;
      tmr_pkg::CS_DIV8:     timer_tick = tap8;
      tmr_pkg::CS_DIV64:    timer_tick = tap64;
      tmr_pkg::CS_DIV256:   timer_tick = tap256;
      tmr_pkg::CS_DIV1024:  timer_tick = tap1024;
      tmr_pkg::CS_EXT_FALL: timer_tick = ext_f;
      tmr_pkg::CS_EXT_RISE: timer_tick = ext_r;
      default:              timer_tick = 1'b0;
    endcase
  end

endmodule

// >>> hw/tmr16.sv
// 16-bit timer/counter: byte register port, shared high-byte latch,
// counter, two compare channels, capture unit, flags and mask.
// Assumes an 8-bit master with one-cycle strobes; read data next cycle.
//
// Behaviour
// [R1] 16-bit registers moved as two byte accesses
// [R2] One shared high-byte latch per timer
// [R3] Low-byte write loads latch plus low byte
// [R4] Low-byte read copies upper byte to latch
// [R5] Compare reads bypass the latch entirely
// [R6] Master writes high first, reads low first
// [R7] Master blocks interrupts across both byte accesses
// [R8] Control registers plain 8-bit read/write
// [R9] Flags in one register, each maskable
// [R10] Clock select picks tick; none means idle
// [R11] Buffered compares compared continuously, drive waves
// [R12] Compare match sets channel match flag
// [R13] Capture edge copies counter, optional filter
// [R14] BOTTOM is counter equal to zero
// [R15] MAX is counter equal to all ones
// [R16] TOP chosen by mode from fixed/compare/capture
// [R17] Compare A as TOP: no PWM on A
// [R18] Capture as TOP frees channel A PWM
// [R19] CPU counter write beats count or clear
// [R20] Capture writable only when capture is TOP
// [R21] Latch changes only on low read, high write
// [R22] Non-compare high read returns latch contents
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module tmr16 (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire tmr_pkg::tmr_bus_req_t bus_req,
  output logic [7:0]                 rdata,
  input  wire logic                  ext_count_pin,
  input  wire logic                  capture_pin,
  input  wire logic                  comp_in,
  output logic                       wave_out_a,
  output logic                       wave_out_b,
  output logic [3:0]                 irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic [15:0] count_q;
  logic [15:0] capture_q;
  logic [15:0] cmp_a_buf_q;
  logic [15:0] cmp_b_buf_q;
  logic [15:0] cmp_a_act_q;
  logic [15:0] cmp_b_act_q;
  logic [7:0]  latch_q;
  logic [7:0]  flag_q;
  logic [7:0]  mask_q;
  logic [7:0]  rdata_q;
  logic        wave_a_q;
  logic        wave_b_q;
  logic [tmr_pkg::FLT_LEN-1:0] flt_q;
  logic        flt_out_q;
  logic        trig_p_q;
  logic        timer_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding
  function automatic logic is_pwm(input logic [3:0] m);
    case (tmr_pkg::tmr_mode_t'(m))
      tmr_pkg::MD_PWM8, tmr_pkg::MD_PWM9, tmr_pkg::MD_PWM10,
      tmr_pkg::MD_PWM_CAP, tmr_pkg::MD_PWM_A: is_pwm = 1'b1;
      default:                               is_pwm = 1'b0;
    endcase
  endfunction

  function automatic logic cap_top(input logic [3:0] m);
    cap_top = (m == tmr_pkg::MD_CTC_CAP) || (m == tmr_pkg::MD_PWM_CAP);
  endfunction

  function automatic logic acc(input tmr_pkg::tmr_bus_req_t b,
                               input logic [7:0] a,
                               input logic w);
    acc = (w ? b.wr : b.rd) && (b.addr == a);
  endfunction

  wire [3:0] mode = {ctrl_b_q[tmr_pkg::CB_MODE_HI +: 2],
                     ctrl_a_q[tmr_pkg::CA_MODE_LO +: 2]};
  wire       pwm_on   = is_pwm(mode);
  wire       cap_is_top = cap_top(mode);
  wire       a_is_top = (mode == tmr_pkg::MD_CTC_A) || (mode == tmr_pkg::MD_PWM_A);
  wire       at_bottom = (count_q == tmr_pkg::BOTTOM_VAL); // see [R14]
  wire       at_max    = (count_q == tmr_pkg::MAX_VAL);    // see [R15]

  // see [R16]
  wire [15:0] top_val =
    (mode == tmr_pkg::MD_PWM8)  ? tmr_pkg::TOP_8BIT  :
    (mode == tmr_pkg::MD_PWM9)  ? tmr_pkg::TOP_9BIT  :
    (mode == tmr_pkg::MD_PWM10) ? tmr_pkg::TOP_10BIT :
    a_is_top                    ? cmp_a_act_q        :
    cap_is_top                  ? capture_q          : tmr_pkg::MAX_VAL;
  wire        at_top = (count_q == top_val);

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  wire wr_cnt_lo  = acc(bus_req, tmr_pkg::ADR_CNT_LO, 1'b1);
  wire wr_cap_lo  = acc(bus_req, tmr_pkg::ADR_CAP_LO, 1'b1);
  wire wr_cmpa_lo = acc(bus_req, tmr_pkg::ADR_CMPA_LO, 1'b1);
  wire wr_cmpb_lo = acc(bus_req, tmr_pkg::ADR_CMPB_LO, 1'b1);
  wire wr_hi      = acc(bus_req, tmr_pkg::ADR_CNT_HI, 1'b1) |
                    acc(bus_req, tmr_pkg::ADR_CAP_HI, 1'b1) |
                    acc(bus_req, tmr_pkg::ADR_CMPA_HI, 1'b1) |
                    acc(bus_req, tmr_pkg::ADR_CMPB_HI, 1'b1);
  wire wr_flag    = acc(bus_req, tmr_pkg::ADR_FLAG, 1'b1);
  wire rd_cnt_lo  = acc(bus_req, tmr_pkg::ADR_CNT_LO, 1'b0);
  wire rd_cap_lo  = acc(bus_req, tmr_pkg::ADR_CAP_LO, 1'b0);
  wire [15:0] wr_word = {latch_q, bus_req.wdata}; // see [R3]

  ////////////////////////////////////////////////////////////////////////////
  // Shared high-byte latch
  // see [R2] [R21]
  wire [7:0] latch_d = wr_hi     ? bus_req.wdata     :
                       rd_cnt_lo ? count_q[15:8]     :
                       rd_cap_lo ? capture_q[15:8]   : latch_q; // see [R4]

  ////////////////////////////////////////////////////////////////////////////
  // Read selection; compare highs come straight from their buffers
  wire [7:0] rd_sel =
    (bus_req.addr == tmr_pkg::ADR_CTRL_A)  ? ctrl_a_q            : // see [R8]
    (bus_req.addr == tmr_pkg::ADR_CTRL_B)  ? ctrl_b_q            :
    (bus_req.addr == tmr_pkg::ADR_CNT_LO)  ? count_q[7:0]        :
    (bus_req.addr == tmr_pkg::ADR_CNT_HI)  ? latch_q             : // see [R22]
    (bus_req.addr == tmr_pkg::ADR_CAP_LO)  ? capture_q[7:0]      :
    (bus_req.addr == tmr_pkg::ADR_CAP_HI)  ? latch_q             : // see [R22]
    (bus_req.addr == tmr_pkg::ADR_CMPA_LO) ? cmp_a_buf_q[7:0]    :
    (bus_req.addr == tmr_pkg::ADR_CMPA_HI) ? cmp_a_buf_q[15:8]   : // see [R5]
    (bus_req.addr == tmr_pkg::ADR_CMPB_LO) ? cmp_b_buf_q[7:0]    :
    (bus_req.addr == tmr_pkg::ADR_CMPB_HI) ? cmp_b_buf_q[15:8]   : // see [R5]
    (bus_req.addr == tmr_pkg::ADR_FLAG)    ? flag_q              :
    (bus_req.addr == tmr_pkg::ADR_MASK)    ? mask_q              : tmr_pkg::RST_BYTE;
  wire [7:0] rdata_d = bus_req.rd ? rd_sel : tmr_pkg::RST_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Counter: CPU write first, then wrap at TOP, then count
  // see [R1] [R19]
  wire [15:0] count_d = wr_cnt_lo              ? wr_word            :
                        (timer_tick && at_top) ? tmr_pkg::BOTTOM_VAL :
                        timer_tick             ? count_q + 16'h0001 : count_q;

  // Buffered compares go live at once outside PWM, else at TOP
  wire        cmp_load = !pwm_on || (timer_tick && at_top); // see [R11] [R17]
  wire        match_a  = (count_q == cmp_a_act_q);          // see [R11]
  wire        match_b  = (count_q == cmp_b_act_q);

  ////////////////////////////////////////////////////////////////////////////
  // Capture trigger: source, optional four-sample filter, edge
  wire trig_raw  = ctrl_a_q[tmr_pkg::CA_TRIG_SRC] ? comp_in : capture_pin;
  wire flt_all1  = &flt_q;
  wire flt_all0  = ~|flt_q;
  wire flt_d     = flt_all1 ? 1'b1 : flt_all0 ? 1'b0 : flt_out_q;
  wire trig_now  = ctrl_b_q[tmr_pkg::CB_FILT] ? flt_out_q : flt_q[0];
  wire trig_edge = ctrl_b_q[tmr_pkg::CB_EDGE] ? (trig_now & ~trig_p_q)
                                              : (~trig_now & trig_p_q);
  wire cap_ev    = trig_edge && !cap_is_top; // see [R13]

  // see [R20]
  wire [15:0] capture_d = cap_ev                  ? count_q :
                          (wr_cap_lo && cap_is_top) ? wr_word : capture_q;

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set beats a software clear in the same cycle
  wire [7:0] flag_set = {2'b00, cap_ev, 2'b00,
                         timer_tick & match_b,                   // see [R12]
                         timer_tick & match_a,                   // see [R12]
                         timer_tick & at_top};
  wire [7:0] flag_clr = wr_flag ? bus_req.wdata : tmr_pkg::RST_BYTE;
  wire [7:0] flag_d   = ((flag_q & ~flag_clr) | flag_set) & tmr_pkg::FLAG_USED;

  ////////////////////////////////////////////////////////////////////////////
  // Wave outputs
  wire wave_a_d = !ctrl_a_q[tmr_pkg::CA_WAVE_A] ? 1'b0 :
                  pwm_on ? (!a_is_top && (count_q < cmp_a_act_q)) : // see [R17] [R18]
                  (timer_tick && match_a) ? ~wave_a_q : wave_a_q;
  wire wave_b_d = !ctrl_a_q[tmr_pkg::CA_WAVE_B] ? 1'b0 :
                  pwm_on ? (count_q < cmp_b_act_q) :
                  (timer_tick && match_b) ? ~wave_b_q : wave_b_q;

  ////////////////////////////////////////////////////////////////////////////
  tmr_tick_sel u_tick (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .clk_sel       (ctrl_b_q[tmr_pkg::CB_CLK_LO +: 3]),
    .ext_count_pin (ext_count_pin),
    .timer_tick    (timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_a_q    <= tmr_pkg::RST_BYTE;
      ctrl_b_q    <= tmr_pkg::RST_BYTE;
      mask_q      <= tmr_pkg::RST_BYTE;
      latch_q     <= tmr_pkg::RST_BYTE;
      flag_q      <= tmr_pkg::RST_BYTE;
      rdata_q     <= tmr_pkg::RST_BYTE;
      count_q     <= tmr_pkg::RST_WORD;
      capture_q   <= tmr_pkg::RST_WORD;
      cmp_a_buf_q <= tmr_pkg::RST_WORD;
      cmp_b_buf_q <= tmr_pkg::RST_WORD;
      cmp_a_act_q <= tmr_pkg::RST_WORD;
      cmp_b_act_q <= tmr_pkg::RST_WORD;
    end
    else
    begin
      if (acc(bus_req, tmr_pkg::ADR_CTRL_A, 1'b1)) ctrl_a_q <= bus_req.wdata;
      if (acc(bus_req, tmr_pkg::ADR_CTRL_B, 1'b1)) ctrl_b_q <= bus_req.wdata;
      if (acc(bus_req, tmr_pkg::ADR_MASK, 1'b1))   mask_q   <= bus_req.wdata;
      if (wr_cmpa_lo) cmp_a_buf_q <= wr_word;
      if (wr_cmpb_lo) cmp_b_buf_q <= wr_word;
      if (cmp_load)   cmp_a_act_q <= cmp_a_buf_q;
      if (cmp_load)   cmp_b_act_q <= cmp_b_buf_q;
      latch_q   <= latch_d;
      flag_q    <= flag_d;
      rdata_q   <= rdata_d;
      count_q   <= count_d;
      capture_q <= capture_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flt_q     <= '0;
      flt_out_q <= 1'b0;
      trig_p_q  <= 1'b0;
      wave_a_q  <= 1'b0;
      wave_b_q  <= 1'b0;
    end
    else
    begin
      flt_q     <= {flt_q[tmr_pkg::FLT_LEN-2:0], trig_raw};
      flt_out_q <= flt_d;
      trig_p_q  <= trig_now;
      wave_a_q  <= wave_a_d;
      wave_b_q  <= wave_b_d;
    end
  end

  assign rdata      = rdata_q;
  assign wave_out_a = wave_a_q;
  assign wave_out_b = wave_b_q;
  // see [R9]
  assign irq_req    = {flag_q[tmr_pkg::FL_CAP], flag_q[tmr_pkg::FL_MB],
                       flag_q[tmr_pkg::FL_MA], flag_q[tmr_pkg::FL_OVF]} &
                      {mask_q[tmr_pkg::FL_CAP], mask_q[tmr_pkg::FL_MB],
                       mask_q[tmr_pkg::FL_MA], mask_q[tmr_pkg::FL_OVF]};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_cnt_lo_wr;
    bus_req.wr && (bus_req.addr == tmr_pkg::ADR_CNT_LO);
  endsequence
  sequence s_cnt_lo_rd;
    bus_req.rd && (bus_req.addr == tmr_pkg::ADR_CNT_LO);
  endsequence

  property p_lo_write;
    s_cnt_lo_wr |=> count_q == {$past(latch_q), $past(bus_req.wdata)};
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("Counter word not loaded"); // see [R3]

  property p_lo_read;
    s_cnt_lo_rd |=> (latch_q == $past(count_q[15:8])) && (rdata == $past(count_q[7:0]));
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("Low read did not fill latch"); // see [R4]

  property p_cmp_read;
    bus_req.rd && (bus_req.addr == tmr_pkg::ADR_CMPA_HI)
      |=> (rdata == $past(cmp_a_buf_q[15:8])) && $stable(latch_q);
  endproperty
  a_cmp_read: assert property (p_cmp_read) else $error("Compare read used latch"); // see [R5]

  property p_wr_prio;
    s_cnt_lo_wr ##0 timer_tick |=> count_q == $past(wr_word);
  endproperty
  a_wr_prio: assert property (p_wr_prio) else $error("Count beat CPU write"); // see [R19]

  property p_wrap;
    timer_tick && at_max && (mode == tmr_pkg::MD_NORMAL) && !wr_cnt_lo
      |=> at_bottom && flag_q[tmr_pkg::FL_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("No wrap at MAX"); // see [R15]

  property p_match;
    timer_tick && match_a |=> flag_q[tmr_pkg::FL_MA];
  endproperty
  a_match: assert property (p_match) else $error("Match flag not set"); // see [R12]

  property p_capture;
    cap_ev |=> (capture_q == $past(count_q)) && flag_q[tmr_pkg::FL_CAP];
  endproperty
  a_capture: assert property (p_capture) else $error("Capture missed"); // see [R13]

  property p_hi_read;
    bus_req.rd && (bus_req.addr == tmr_pkg::ADR_CNT_HI) |=> rdata == $past(latch_q);
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("High read not latch"); // see [R22]

  property p_latch_hold;
    !wr_hi && !rd_cnt_lo && !rd_cap_lo |=> $stable(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Latch changed"); // see [R21]

  property p_a_top_nopwm;
    a_is_top && pwm_on |=> !wave_out_a;
  endproperty
  a_a_top_nopwm: assert property (p_a_top_nopwm) else $error("PWM on A at TOP"); // see [R17]

  property p_idle;
    (ctrl_b_q[tmr_pkg::CB_CLK_LO +: 3] == tmr_pkg::CS_OFF) && !wr_cnt_lo |=> $stable(count_q);
  endproperty
  a_idle: assert property (p_idle) else $error("Counter moved with no source"); // see [R10]

endmodule

// >>> tb/tmr_cpu_model.sv
// CPU-side master model: byte and 16-bit register accesses.
// Assumes the timer answers a read in the cycle after the strobe.
`timescale 1ns/1ns
module tmr_cpu_model (
  input  wire logic             ref_clk,
  input  wire logic [7:0]       rdata,
  output tmr_pkg::tmr_bus_req_t bus_req
);
  ////////////////////////////////////////////////////////////////////////////
  initial bus_req = '0;

  // One strobe cycle; released address and data show the inverse of their last value, strobes go low
  task automatic req(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    req(a, d, 1'b1);
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    req(a, 8'h00, 1'b0);
    @(negedge ref_clk);
    d = rdata;
  endtask

  // Both byte accesses one idle cycle apart, no other access between them
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr8(a + 8'h01, v[15:8]);
    wr8(a, v[7:0]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 8'h01, v[15:8]);
  endtask
endmodule

// >>> tb/timer16_byte_access_tb.sv
// Self-checking bench for the 16-bit timer register block.
// Assumes the timer package and the CPU model are compiled first.
`timescale 1ns/1ns
module timer16_byte_access_tb;
  ////////////////////////////////////////////////////////////////////////////
  logic                  ref_clk;
  logic                  resetn;
  logic                  ext_count_pin;
  logic                  capture_pin;
  logic                  comp_in;
  logic                  wave_out_a;
  logic                  wave_out_b;
  logic [3:0]            irq_req;
  logic [7:0]            rdata;
  logic [7:0]            b;
  logic [15:0]           w;
  logic [15:0]           top;
  logic [15:0]           hi;
  logic [15:0]           hi_b;
  logic [31:0]           v;
  tmr_pkg::tmr_bus_req_t bus_req;
  integer                seed = 32'he31a3950;
  int                    n_fail = 0;
  int                    checked = 0;
  int                    cycle_cnt = 0;

  tmr16 i_tmr16 (
    .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .ext_count_pin(ext_count_pin), .capture_pin(capture_pin), .comp_in(comp_in),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq_req(irq_req)
  );

  tmr_cpu_model i_tmr_cpu_model (.ref_clk(ref_clk), .rdata(rdata), .bus_req(bus_req));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_top(input int m);
    case (m)
      1: return tmr_pkg::TOP_8BIT;
      2: return tmr_pkg::TOP_9BIT;
      3: return tmr_pkg::TOP_10BIT;
      default: return tmr_pkg::MAX_VAL;
    endcase
  endfunction

  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    i_tmr_cpu_model.wr8(a, d);
  endtask

  task automatic r8(input logic [7:0] a, output logic [7:0] d);
    i_tmr_cpu_model.rd8(a, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    ext_count_pin = 1'b0;
    capture_pin = 1'b0;
    comp_in = 1'b0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, unmapped place at 0c
    for (int a = 0; a < 13; a++)
    begin
      r8(8'(a), b);
      chk({8'h00, b}, {8'h00, tmr_pkg::RST_BYTE});
    end
    chk({12'h000, irq_req}, 16'h0000);
    // Control and mask registers
    repeat (4)
    begin
      v = $random(seed);
      w8(tmr_pkg::ADR_CTRL_A, v[7:0]);
      w8(tmr_pkg::ADR_CTRL_B, v[15:8] & 8'hf8);
      w8(tmr_pkg::ADR_MASK, v[23:16] & tmr_pkg::FLAG_USED);
      r8(tmr_pkg::ADR_CTRL_A, b);
      chk({8'h00, b}, {8'h00, v[7:0]});
      r8(tmr_pkg::ADR_CTRL_B, b);
      chk({8'h00, b}, {8'h00, v[15:8] & 8'hf8});
      r8(tmr_pkg::ADR_MASK, b);
      chk({8'h00, b}, {8'h00, v[23:16] & tmr_pkg::FLAG_USED});
    end
    w8(tmr_pkg::ADR_CTRL_A, 8'h00);
    w8(tmr_pkg::ADR_CTRL_B, 8'h00);
    // Counter round trip with the clock stopped, then latch isolation
    repeat (4)
    begin
      w = 16'($random(seed));
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CNT_LO, w);
      repeat (8) @(posedge ref_clk);
      i_tmr_cpu_model.rd16(tmr_pkg::ADR_CNT_LO, top);
      chk(top, w);
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CMPA_LO, ~w);
      w8(tmr_pkg::ADR_CNT_HI, w[7:0]);
      r8(tmr_pkg::ADR_CMPA_HI, b);
      chk({8'h00, b}, {8'h00, ~w[15:8]});
      r8(tmr_pkg::ADR_CNT_HI, b);
      chk({8'h00, b}, {8'h00, w[7:0]});
    end
    // CPU write while counting at full rate; two ticks follow it
    w = 16'($random(seed)) & 16'h7fff;
    w8(tmr_pkg::ADR_CTRL_B, 8'h01);
    i_tmr_cpu_model.wr16(tmr_pkg::ADR_CNT_LO, w);
    w8(tmr_pkg::ADR_CTRL_B, 8'h00);
    i_tmr_cpu_model.rd16(tmr_pkg::ADR_CNT_LO, top);
    chk(top, w + 16'h0002);
    // Divide-by-8 tap over 32 cycles, then five pulses on each pin edge
    for (int c = 5; c < 8; c++)
    begin
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CNT_LO, 16'h0000);
      w8(tmr_pkg::ADR_CTRL_B, (c == 5) ? 8'h02 : 8'(c));
      repeat (5)
      begin
        @(posedge ref_clk) ext_count_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ext_count_pin <= 1'b0;
        repeat (2) @(posedge ref_clk);
      end
      w8(tmr_pkg::ADR_CTRL_B, 8'h00);
      i_tmr_cpu_model.rd16(tmr_pkg::ADR_CNT_LO, top);
      chk(top, (c == 5) ? 16'h0004 : 16'h0005);
    end
    // Compare matches, flags and masking
    w = (16'($random(seed)) & 16'h7fff) | 16'h0100;
    i_tmr_cpu_model.wr16(tmr_pkg::ADR_CMPA_LO, w);
    i_tmr_cpu_model.wr16(tmr_pkg::ADR_CMPB_LO, w + 16'h0008);
    i_tmr_cpu_model.wr16(tmr_pkg::ADR_CNT_LO, w - 16'h0004);
    w8(tmr_pkg::ADR_FLAG, 8'hff);
    w8(tmr_pkg::ADR_MASK, tmr_pkg::FLAG_USED);
    w8(tmr_pkg::ADR_CTRL_B, 8'h01);
    repeat (30) @(posedge ref_clk);
    w8(tmr_pkg::ADR_CTRL_B, 8'h00);
    r8(tmr_pkg::ADR_FLAG, b);
    chk({8'h00, b}, 16'h0006);
    chk({12'h000, irq_req}, 16'h0006);
    w8(tmr_pkg::ADR_MASK, 8'h02);
    @(negedge ref_clk);
    chk({12'h000, irq_req}, 16'h0002);
    w8(tmr_pkg::ADR_FLAG, 8'h02);
    r8(tmr_pkg::ADR_FLAG, b);
    chk({8'h00, b}, 16'h0004);
    // Wrap at TOP for each fixed TOP
    for (int m = 0; m < 4; m++)
    begin
      w8(tmr_pkg::ADR_CTRL_A, 8'(m));
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CNT_LO, exp_top(m) - 16'h0010);
      w8(tmr_pkg::ADR_FLAG, 8'hff);
      w8(tmr_pkg::ADR_CTRL_B, 8'h01);
      repeat (30) @(posedge ref_clk);
      w8(tmr_pkg::ADR_CTRL_B, 8'h00);
      i_tmr_cpu_model.rd16(tmr_pkg::ADR_CNT_LO, top);
      chk(top, 16'h000f);
      r8(tmr_pkg::ADR_FLAG, b);
      chk({15'h0000, b[tmr_pkg::FL_OVF]}, 16'h0001);
    end
    // Capture from the pin, then from the comparator through the filter
    for (int s = 0; s < 2; s++)
    begin
      w8(tmr_pkg::ADR_CTRL_A, s[0] ? 8'h04 : 8'h00);
      w8(tmr_pkg::ADR_CTRL_B, s[0] ? 8'hc0 : 8'h40);
      w = 16'($random(seed));
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CNT_LO, w);
      w8(tmr_pkg::ADR_FLAG, 8'hff);
      if (s[0])
        comp_in <= 1'b1;
      else
        capture_pin <= 1'b1;
      repeat (12) @(posedge ref_clk);
      i_tmr_cpu_model.rd16(tmr_pkg::ADR_CAP_LO, top);
      chk(top, w);
      r8(tmr_pkg::ADR_FLAG, b);
      chk({8'h00, b}, 16'h0020);
    end
    // Capture write refused outside capture-TOP modes
    i_tmr_cpu_model.wr16(tmr_pkg::ADR_CAP_LO, ~w);
    i_tmr_cpu_model.rd16(tmr_pkg::ADR_CAP_LO, top);
    chk(top, w);
    // PWM on A: free with capture TOP, silent with compare-A TOP; B in both
    for (int k = 0; k < 2; k++)
    begin
      w8(tmr_pkg::ADR_CTRL_A, 8'h00);
      w8(tmr_pkg::ADR_CTRL_B, 8'h18);
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CAP_LO, 16'h0040);
      i_tmr_cpu_model.rd16(tmr_pkg::ADR_CAP_LO, top);
      chk(top, 16'h0040);
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CMPA_LO, k[0] ? 16'h0040 : 16'h0020);
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CMPB_LO, 16'h0010);
      i_tmr_cpu_model.wr16(tmr_pkg::ADR_CNT_LO, 16'h0000);
      w8(tmr_pkg::ADR_CTRL_A, k[0] ? 8'ha3 : 8'ha2);
      w8(tmr_pkg::ADR_CTRL_B, 8'h19);
      hi = 16'h0000;
      hi_b = 16'h0000;
      repeat (130) @(negedge ref_clk)
      begin
        hi = hi + {15'h0000, wave_out_a};
        hi_b = hi_b + {15'h0000, wave_out_b};
      end
      w8(tmr_pkg::ADR_CTRL_B, 8'h00);
      chk({15'h0000, hi_b >= 16'd20 && hi_b <= 16'd45}, 16'h0001);
      if (k[0])
        chk(hi, 16'h0000);
      else
        chk({15'h0000, hi >= 16'd40 && hi <= 16'd90}, 16'h0001);
    end
    end_of_test();
  end
endmodule
